/* File: verilog/dsac_pkg.sv */
`default_nettype none
package dsac_pkg;

  // data path and address widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int NEAR_W = 13;

  // address steps for pointer post-modify
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  // stack underflow floor: addresses below it belong to the sfr area
  localparam logic [15:0] SFR_FLOOR = 16'h0800;
  // stack pointer value after reset
  localparam logic [15:0] SP_RESET  = 16'h0800;

  // byte lane enables
  localparam logic [1:0] BE_LOW  = 2'h1;
  localparam logic [1:0] BE_HIGH = 2'h2;
  localparam logic [1:0] BE_WORD = 2'h3;

  // how the x effective address is formed
  typedef enum logic [1:0] {
    AM_INDIRECT = 2'h0,  // pointer supplies the address
    AM_NEAR     = 2'h1,  // 13-bit absolute field, near region
    AM_ABS16    = 2'h3   // 16-bit absolute field, move only
  } dsac_amode_e;

  // what a stack push carries
  typedef enum logic [1:0] {
    PK_DATA    = 2'h0,  // plain data word
    PK_PC_LOW  = 2'h1,  // low program counter word
    PK_PC_CALL = 2'h3,  // upper pc bits, call
    PK_PC_EXC  = 2'h2   // upper pc bits, exception entry
  } dsac_push_e;

  // one x-bus request from the address generator
  typedef struct packed {
    logic              valid;    // request present
    logic              we;       // write (else read)
    logic              byte_op;  // byte size (else word)
    logic              dual;     // dual_operand_instr prefetch
    logic              postinc;  // post-modify the pointer
    logic              bitrev;   // bit-reversed mode active
    dsac_amode_e       mode;     // address source
    logic [ADDR_W-1:0] ea;       // pointer or absolute field
    logic [ADDR_W-1:0] brev_ea;  // bit-reversed address
    logic [DATA_W-1:0] wdata;    // write data
  } dsac_xreq_s;

  // one stack operation
  typedef struct packed {
    logic              push;     // push request
    logic              pop;      // pop request
    dsac_push_e        kind;     // push payload kind
    logic [DATA_W-1:0] wdata;    // data or pc bits
    logic [7:0]        status_low_byte;  // status byte for exceptions
  } dsac_stk_s;

endpackage
`default_nettype wire

/* File: verilog/dsac_lane.sv */
`timescale 1ns/1ps
`default_nettype none
// byte lane steering for the x path, purely combinational
module dsac_lane
  import dsac_pkg::*;
(
  // access shape
  input  wire logic              byte_op,
  input  wire logic              lsb,
  input  wire logic              zero,
  // data in
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [DATA_W-1:0] rdata,
  // data out
  output logic      [1:0]        be,
  output logic      [DATA_W-1:0] wdata_o,
  output logic      [DATA_W-1:0] rdata_o
);

  // lane enables and replicated byte for writes
  always_comb begin
    if (byte_op) begin
      be      = lsb ? BE_HIGH : BE_LOW;
      wdata_o = {wdata[7:0], wdata[7:0]};
    end else begin
      be      = BE_WORD;
      wdata_o = wdata;
    end
  end

  // read steering: selected byte lands in the low lane
  always_comb begin
    if (zero) begin
      rdata_o = '0;
    end else if (byte_op) begin
      rdata_o = {8'h00, lsb ? rdata[15:8] : rdata[7:0]};
    end else begin
      rdata_o = rdata;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/dsac_stack.sv */
`timescale 1ns/1ps
`default_nettype none
// stack pointer, stack limit and stack error detection
module dsac_stack
  import dsac_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              srst,
  // stack operations
  input  wire logic              push,
  input  wire logic              pop,
  // software writes
  input  wire logic              sp_we,
  input  wire logic [ADDR_W-1:0] sp_wdata,
  input  wire logic              lim_we,
  input  wire logic [ADDR_W-1:0] lim_wdata,
  // state and checks
  output logic      [ADDR_W-1:0] sp_q,
  output logic      [ADDR_W-1:0] lim_q,
  output logic      [ADDR_W-1:0] ea,
  output logic                   err
);

  logic [ADDR_W-1:0] sp_d;  // next stack pointer

  // push uses the free word, pop the word below it
  always_comb begin
    ea   = push ? sp_q : sp_q - STEP_WORD;
    sp_d = sp_q;
    if (sp_we) begin
      sp_d = {sp_wdata[15:1], 1'b0};
    end else if (push) begin
      sp_d = sp_q + STEP_WORD;
    end else if (pop) begin
      sp_d = sp_q - STEP_WORD;
    end
  end

  // push addresses are checked against limit, push and pop addresses against sfr floor;
  // equal to limit is still legal, one beyond traps
  always_comb begin
    err = ((push && (sp_q > lim_q))
        || ((push || pop) && (ea < SFR_FLOOR)));
  end

  // stack pointer register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sp_q <= SP_RESET;
    end else begin
      sp_q <= sp_d;
    end
  end

  // limit is left without reset; bit 0 is held low
  always_ff @(posedge sys_clk) begin
    if (lim_we) begin
      lim_q <= {lim_wdata[15:1], 1'b0};
    end
  end

endmodule
`default_nettype wire

/* File: verilog/dsac_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dsac_top
  import dsac_pkg::*;
#(
  parameter logic [15:0] Y_LO   = 16'h0900,  // first y space address
  parameter logic [15:0] Y_HI   = 16'h09ff,  // last y space address
  parameter logic [15:0] MEM_HI = 16'h0fff   // last implemented address
)
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              srst,
  // x access from the x address generator
  input  wire dsac_xreq_s        x_req,
  // y prefetch from the y address generator
  input  wire logic              y_req,
  input  wire logic [ADDR_W-1:0] y_ea,
  // stack operations and control
  input  wire dsac_stk_s         stk,
  input  wire logic              sp_we,
  input  wire logic [ADDR_W-1:0] sp_wdata,
  input  wire logic              stk_lim_we,
  input  wire logic [ADDR_W-1:0] stk_lim_wdata,
  // trap acceptance from exception logic
  input  wire logic              addr_err_ack,
  input  wire logic              stk_err_ack,
  // memory x port
  output logic      [ADDR_W-1:0] mem_x_addr,
  output logic                   mem_x_re,
  output logic                   mem_x_we,
  output logic      [1:0]        mem_x_be,
  output logic      [DATA_W-1:0] mem_x_wdata,
  input  wire logic [DATA_W-1:0] mem_x_rdata,
  // memory y port, read only
  output logic      [ADDR_W-1:0] mem_y_addr,
  output logic                   mem_y_re,
  input  wire logic [DATA_W-1:0] mem_y_rdata,
  // read returns to the core
  output logic                   x_rvalid,
  output logic      [DATA_W-1:0] x_rdata,
  output logic      [1:0]        wreg_be,
  output logic                   y_rvalid,
  output logic      [DATA_W-1:0] y_rdata,
  // pointer update
  output logic                   ptr_upd,
  output logic      [ADDR_W-1:0] ptr_next,
  // stack state
  output logic      [ADDR_W-1:0] stack_pointer_reg,
  output logic      [ADDR_W-1:0] stack_limit_reg,
  // trap requests
  output logic                   addr_err_req,
  output logic                   stk_err_req
);

  // map parameters must describe a y block inside real memory
  initial begin
    if ((Y_LO > Y_HI) || (Y_HI > MEM_HI) || Y_LO[0] || !Y_HI[0]) begin
      $error("dsac_top: bad data space map parameters");
    end
  end

  // registered outputs
  logic [ADDR_W-1:0] mem_x_addr_q;   // x word address to memory
  logic              mem_x_re_q;     // x read strobe
  logic              mem_x_we_q;     // x write strobe
  logic [1:0]        mem_x_be_q;     // x lane enables
  logic [DATA_W-1:0] mem_x_wdata_q;  // x write data
  logic [ADDR_W-1:0] mem_y_addr_q;   // y word address
  logic              mem_y_re_q;     // y read strobe
  logic              x_rvalid_q;     // x read data valid
  logic [DATA_W-1:0] x_rdata_q;      // x read data
  logic [1:0]        wreg_be_q;      // register lane write enables
  logic              y_rvalid_q;     // y read data valid
  logic [DATA_W-1:0] y_rdata_q;      // y read data
  logic              ptr_upd_q;      // pointer update strobe
  logic [ADDR_W-1:0] ptr_next_q;     // updated pointer value
  logic              addr_err_q;     // held address error request
  logic              stk_err_q;      // held stack error request

  // read context carried to the data return cycle
  logic              rd_byte_q;      // byte read in flight
  logic              rd_lsb_q;       // byte select of that read
  logic              rd_zero_q;      // force zero on return
  logic              y_zero_q;       // force zero on y return

  // combinational x address work
  logic [ADDR_W-1:0] x_ea;           // address after mode decode
  logic [ADDR_W-1:0] x_acc_ea;       // address used for access
  logic              x_go;           // x request accepted
  logic              x_odd;          // word access at odd address
  logic              x_in_y;         // address inside y block
  logic              x_impl;         // address implemented
  logic              x_rzero;        // x read must return zero
  logic              x_wok;          // x write may reach memory
  logic [1:0]        x_be;           // lane enables from lane unit
  logic [DATA_W-1:0] x_wlane;        // lane-replicated write data
  logic [DATA_W-1:0] x_rlane;        // steered read data

  // combinational y address work
  logic              y_in;           // y address inside y block
  logic              y_odd;          // y address misaligned
  logic              y_zero;         // y read must return zero

  // stack work
  logic              stk_go;         // stack operation this cycle
  logic [ADDR_W-1:0] stk_ea;         // address from stack pointer
  logic              stk_err;        // stack check failed
  logic [DATA_W-1:0] push_word;      // word to place on stack

  // events raising the trap requests
  logic              addr_err_ev;    // misaligned access seen
  logic              stk_err_ev;     // stack limit or floor hit

  // stack pointer and limit live in their own unit
  dsac_stack u_stack (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .push      (stk.push),
    .pop       (stk.pop & ~stk.push),
    .sp_we     (sp_we),
    .sp_wdata  (sp_wdata),
    .lim_we    (stk_lim_we),
    .lim_wdata (stk_lim_wdata),
    .sp_q      (stack_pointer_reg),
    .lim_q     (stack_limit_reg),
    .ea        (stk_ea),
    .err       (stk_err)
  );

  // stack limit write followed at once by a push is left to
  // software; the compare always uses the stored limit
  assign stk_go = stk.push | stk.pop;

  // effective address by addressing mode
  always_comb begin
    unique case (x_req.mode)
      AM_NEAR: begin
        x_ea = {3'h0, x_req.ea[NEAR_W-1:0]};
      end
      AM_ABS16: begin
        x_ea = x_req.ea;
      end
      default: begin
        x_ea = x_req.ea;
      end
    endcase
  end

  // bit reversal only reshapes x write addresses
  always_comb begin
    if (x_req.we && x_req.bitrev) begin
      x_acc_ea = x_req.brev_ea;
    end else begin
      x_acc_ea = x_ea;
    end
  end

  // space and alignment checks for the x request
  always_comb begin
    x_go    = x_req.valid & ~stk_go;
    x_odd   = ~x_req.byte_op & x_acc_ea[0];
    x_in_y  = (x_acc_ea >= Y_LO) && (x_acc_ea <= Y_HI);
    x_impl  = (x_acc_ea <= MEM_HI);
    // outside memory, or an x pointer reaching into y in dual mode
    x_rzero = ~x_impl | (x_req.dual & x_in_y);
    // writes see the whole combined space; odd word writes drop
    x_wok   = x_impl & ~x_odd;
  end

  // y prefetch is always a word and must stay inside y space
  always_comb begin
    y_in   = (y_ea >= Y_LO) && (y_ea <= Y_HI);
    y_odd  = y_ea[0];
    y_zero = ~y_in;
  end

  // stack push payload shaping
  always_comb begin
    unique case (stk.kind)
      PK_PC_CALL: begin
        push_word = {8'h00, stk.wdata[7:0]};
      end
      PK_PC_EXC: begin
        push_word = {stk.status_low_byte, stk.wdata[7:0]};
      end
      default: begin
        push_word = stk.wdata;
      end
    endcase
  end

  // x lane steering for requests only; its read output is left unused
  dsac_lane u_lane (
    .byte_op (x_req.byte_op),
    .lsb     (x_acc_ea[0]),
    .zero    (rd_zero_q),
    .wdata   (x_req.wdata),
    .rdata   (mem_x_rdata),
    .be      (x_be),
    .wdata_o (x_wlane),
    .rdata_o ()
  );

  // separate read steering using the context of the earlier cycle
  dsac_lane u_rlane (
    .byte_op (rd_byte_q),
    .lsb     (rd_lsb_q),
    .zero    (rd_zero_q),
    .wdata   ('0),
    .rdata   (mem_x_rdata),
    .be      (),
    .wdata_o (),
    .rdata_o (x_rlane)
  );

  // trap events from this cycle's accesses
  always_comb begin
    addr_err_ev = (x_go & x_odd) | (y_req & y_odd);
    stk_err_ev  = stk_go & stk_err;
  end

  // x memory port: the only path that ever writes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mem_x_addr_q  <= '0;
      mem_x_re_q    <= 1'b0;
      mem_x_we_q    <= 1'b0;
      mem_x_be_q    <= '0;
      mem_x_wdata_q <= '0;
    end else if (stk.push) begin
      // pushes are word writes at the free word
      mem_x_addr_q  <= stk_ea;
      mem_x_re_q    <= 1'b0;
      mem_x_we_q    <= 1'b1;
      mem_x_be_q    <= BE_WORD;
      mem_x_wdata_q <= push_word;
    end else if (stk.pop) begin
      // pops read the word below the pointer
      mem_x_addr_q  <= stk_ea;
      mem_x_re_q    <= 1'b1;
      mem_x_we_q    <= 1'b0;
      mem_x_be_q    <= BE_WORD;
      mem_x_wdata_q <= '0;
    end else if (x_go) begin
      // word address: containing word for bytes and odd reads
      mem_x_addr_q  <= {x_acc_ea[15:1], 1'b0};
      mem_x_re_q    <= ~x_req.we & ~x_rzero;
      mem_x_we_q    <= x_req.we & x_wok;
      mem_x_be_q    <= x_req.we ? x_be : BE_WORD;
      mem_x_wdata_q <= x_wlane;
    end else begin
      mem_x_re_q    <= 1'b0;
      mem_x_we_q    <= 1'b0;
    end
  end

  // y memory port runs alongside x for dual operand prefetch
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mem_y_addr_q <= '0;
      mem_y_re_q   <= 1'b0;
    end else begin
      mem_y_addr_q <= {y_ea[15:1], 1'b0};
      mem_y_re_q   <= y_req & ~y_zero;
    end
  end

  // read context for the return cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_byte_q <= 1'b0;
      rd_lsb_q  <= 1'b0;
      rd_zero_q <= 1'b0;
      y_zero_q  <= 1'b0;
    end else begin
      rd_byte_q <= ~stk_go & x_req.byte_op;
      rd_lsb_q  <= x_acc_ea[0];
      rd_zero_q <= x_go & ~x_req.we & x_rzero;
      y_zero_q  <= y_req & y_zero;  // idle y port must not answer
    end
  end

  // read return, one cycle after the memory strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      x_rvalid_q <= 1'b0;
      x_rdata_q  <= '0;
      wreg_be_q  <= '0;
    end else begin
      // zero reads still answer so the instruction completes
      x_rvalid_q <= mem_x_re_q | rd_zero_q;
      x_rdata_q  <= x_rlane;
      // byte loads only touch the low register lane
      wreg_be_q  <= rd_byte_q ? BE_LOW : BE_WORD;
    end
  end

  // y return: word only, zero when off its own space
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      y_rvalid_q <= 1'b0;
      y_rdata_q  <= '0;
    end else begin
      y_rvalid_q <= mem_y_re_q | y_zero_q;
      y_rdata_q  <= y_zero_q ? '0 : mem_y_rdata;
    end
  end

  // pointer post-modify sized by the operand
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ptr_upd_q  <= 1'b0;
      ptr_next_q <= '0;
    end else begin
      ptr_upd_q  <= x_go & x_req.postinc & (x_req.mode == AM_INDIRECT);
      ptr_next_q <= x_req.ea
                  + (x_req.byte_op ? STEP_BYTE : STEP_WORD);
    end
  end

  // address error held until accepted; a new event beats the ack
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addr_err_q <= 1'b0;
    end else if (addr_err_ev) begin
      addr_err_q <= 1'b1;
    end else if (addr_err_ack) begin
      addr_err_q <= 1'b0;
    end
  end

  // stack error held the same way, kept apart from address errors
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stk_err_q <= 1'b0;
    end else if (stk_err_ev) begin
      stk_err_q <= 1'b1;
    end else if (stk_err_ack) begin
      stk_err_q <= 1'b0;
    end
  end

  // drive the ports from their flops
  assign mem_x_addr   = mem_x_addr_q;
  assign mem_x_re     = mem_x_re_q;
  assign mem_x_we     = mem_x_we_q;
  assign mem_x_be     = mem_x_be_q;
  assign mem_x_wdata  = mem_x_wdata_q;
  assign mem_y_addr   = mem_y_addr_q;
  assign mem_y_re     = mem_y_re_q;
  assign x_rvalid     = x_rvalid_q;
  assign x_rdata      = x_rdata_q;
  assign wreg_be      = wreg_be_q;
  assign y_rvalid     = y_rvalid_q;
  assign y_rdata      = y_rdata_q;
  assign ptr_upd      = ptr_upd_q;
  assign ptr_next     = ptr_next_q;
  assign addr_err_req = addr_err_q;
  assign stk_err_req  = stk_err_q;

endmodule
`default_nettype wire

/* File: verification/dsac_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// data ram seen by the x and y ports; reads are combinational
module dsac_mem_model
  import dsac_pkg::*;
(
  // clock
  input  wire logic              sys_clk,
  // x port
  input  wire logic [ADDR_W-1:0] x_addr,
  input  wire logic              x_re,
  input  wire logic              x_we,
  input  wire logic [1:0]        x_be,
  input  wire logic [DATA_W-1:0] x_wdata,
  output logic      [DATA_W-1:0] x_rdata,
  // y port, read only
  input  wire logic [ADDR_W-1:0] y_addr,
  input  wire logic              y_re,
  output logic      [DATA_W-1:0] y_rdata
);
  logic [DATA_W-1:0] mem [2048];  // 4 kbyte of words
  // fill with a marker so a zero return is never mistaken for data
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 16'hc3c3;
    end
  end
  // lane writes: only the enabled half changes
  always_ff @(posedge sys_clk) begin
    if (x_we && x_be[0]) begin
      mem[x_addr[11:1]][7:0] <= x_wdata[7:0];
    end
    if (x_we && x_be[1]) begin
      mem[x_addr[11:1]][15:8] <= x_wdata[15:8];
    end
  end
  // unselected port shows inverted data, never a stale match
  assign x_rdata = x_re ? mem[x_addr[11:1]] : ~mem[x_addr[11:1]];
  assign y_rdata = y_re ? mem[y_addr[11:1]] : ~mem[y_addr[11:1]];
endmodule
`default_nettype wire

/* File: verification/dsac_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the data space access block
module dsac_top_props
  import dsac_pkg::*;
#(
  parameter logic [15:0] Y_LO   = 16'h0900,
  parameter logic [15:0] Y_HI   = 16'h09ff,
  parameter logic [15:0] MEM_HI = 16'h0fff
)
(
  input wire logic              sys_clk,
  input wire logic              srst,
  input wire dsac_xreq_s        x_req,
  input wire logic              y_req,
  input wire logic [ADDR_W-1:0] y_ea,
  input wire dsac_stk_s         stk,
  input wire logic              stk_lim_we,
  input wire logic [ADDR_W-1:0] stk_lim_wdata,
  input wire logic              addr_err_ack,
  input wire logic              stk_err_ack,
  input wire logic [ADDR_W-1:0] mem_x_addr,
  input wire logic              mem_x_re,
  input wire logic              mem_x_we,
  input wire logic [1:0]        mem_x_be,
  input wire logic              mem_y_re,
  input wire logic              x_rvalid,
  input wire logic [DATA_W-1:0] x_rdata,
  input wire logic [1:0]        wreg_be,
  input wire logic              y_rvalid,
  input wire logic [DATA_W-1:0] y_rdata,
  input wire logic              ptr_upd,
  input wire logic [ADDR_W-1:0] ptr_next,
  input wire logic [ADDR_W-1:0] stack_pointer_reg,
  input wire logic [ADDR_W-1:0] stack_limit_reg,
  input wire logic              addr_err_req,
  input wire logic              stk_err_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // plain pointer access, not displaced by a stack operation
  logic x_go;
  assign x_go = x_req.valid && !stk.push && !stk.pop && !x_req.bitrev
                && x_req.mode == AM_INDIRECT;
  // refused reads: no strobe, then a zero answer
  sequence s_zero_x;
    !mem_x_re ##1 (x_rvalid && x_rdata == 16'h0000);
  endsequence
  sequence s_zero_y;
    !mem_y_re ##1 (y_rvalid && y_rdata == 16'h0000);
  endsequence
  property p_wr_word;
    x_go && x_req.we && !x_req.byte_op && !x_req.ea[0] && x_req.ea <= MEM_HI
    |=> mem_x_we && mem_x_be == BE_WORD && mem_x_addr == $past(x_req.ea);
  endproperty
  a_wr_word: assert property (p_wr_word) else $error("word write lost");
  property p_wr_byte;
    x_go && x_req.we && x_req.byte_op && x_req.ea <= MEM_HI
    |=> mem_x_we && mem_x_be == ($past(x_req.ea[0]) ? BE_HIGH : BE_LOW);
  endproperty
  a_wr_byte: assert property (p_wr_byte) else $error("byte lane wrong");
  property p_rd_byte;
    x_go && !x_req.we && x_req.byte_op && !x_req.dual && x_req.ea <= MEM_HI
    |=> ##1 x_rvalid && wreg_be == BE_LOW && x_rdata[15:8] == 8'h00;
  endproperty
  a_rd_byte: assert property (p_rd_byte) else $error("byte read shape");
  property p_odd;
    x_go && !x_req.byte_op && x_req.ea[0] |=> addr_err_req && !mem_x_we;
  endproperty
  a_odd: assert property (p_odd) else $error("odd word no trap");
  property p_postinc;
    x_go && x_req.postinc |=> ptr_upd && ptr_next == $past(x_req.ea)
      + ($past(x_req.byte_op) ? STEP_BYTE : STEP_WORD);
  endproperty
  a_postinc: assert property (p_postinc) else $error("pointer step");
  property p_oob;
    x_go && !x_req.we && x_req.ea > MEM_HI |=> s_zero_x;
  endproperty
  a_oob: assert property (p_oob) else $error("unimplemented read");
  property p_dual;
    x_go && !x_req.we && x_req.dual && x_req.ea >= Y_LO && x_req.ea <= Y_HI
    |=> s_zero_x;
  endproperty
  a_dual: assert property (p_dual) else $error("x pointer in y");
  property p_y_out;
    y_req && !y_ea[0] && (y_ea < Y_LO || y_ea > Y_HI) |=> s_zero_y;
  endproperty
  a_y_out: assert property (p_y_out) else $error("y pointer in x");
  property p_push;
    stk.push |=> mem_x_we && mem_x_addr == $past(stack_pointer_reg)
      && stack_pointer_reg == $past(stack_pointer_reg) + STEP_WORD;
  endproperty
  a_push: assert property (p_push) else $error("push order");
  property p_pop;
    stk.pop && !stk.push |=> mem_x_re && mem_x_addr == stack_pointer_reg
      && stack_pointer_reg == $past(stack_pointer_reg) - STEP_WORD;
  endproperty
  a_pop: assert property (p_pop) else $error("pop order");
  property p_lim;
    stk_lim_we |=> stack_limit_reg == {$past(stk_lim_wdata[15:1]), 1'b0};
  endproperty
  a_lim: assert property (p_lim) else $error("limit bit zero");
  property p_over;
    stk.push && stack_pointer_reg > stack_limit_reg |=> stk_err_req;
  endproperty
  a_over: assert property (p_over) else $error("overflow no trap");
  property p_under;
    stk.push && stack_pointer_reg < SFR_FLOOR |=> stk_err_req;
  endproperty
  a_under: assert property (p_under) else $error("underflow no trap");
  property p_hold;
    addr_err_req && !addr_err_ack |=> addr_err_req;
  endproperty
  a_hold: assert property (p_hold) else $error("trap dropped");
  property p_hold_s;
    stk_err_req && !stk_err_ack |=> stk_err_req;
  endproperty
  a_hold_s: assert property (p_hold_s) else $error("stack trap dropped");
endmodule
bind dsac_top dsac_top_props #(.Y_LO(Y_LO), .Y_HI(Y_HI), .MEM_HI(MEM_HI))
  u_dsac_top_props (.sys_clk, .srst, .x_req, .y_req, .y_ea, .stk,
  .stk_lim_we, .stk_lim_wdata, .addr_err_ack, .stk_err_ack, .mem_x_addr,
  .mem_x_re, .mem_x_we, .mem_x_be, .mem_y_re, .x_rvalid, .x_rdata, .wreg_be,
  .y_rvalid, .y_rdata, .ptr_upd, .ptr_next, .stack_pointer_reg,
  .stack_limit_reg, .addr_err_req, .stk_err_req);
`default_nettype wire

/* File: verification/dsac_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dsac_top_tb;
  import dsac_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  dsac_xreq_s x_req = '0;
  dsac_stk_s stk = '0;
  logic y_req = 1'b0, sp_we = 1'b0, stk_lim_we = 1'b0;
  logic addr_err_ack = 1'b0, stk_err_ack = 1'b0;
  logic [15:0] y_ea = '0, sp_wdata = '0, stk_lim_wdata = '0;
  logic [15:0] xa, xw, xr, ya, yr, xd, yd, pn, spr, lim;
  logic xre, xwe, yre, xv, yv, pu, aer, ser;
  logic [1:0] xbe, wbe;
  int num_errors = 0;
  int comparisons = 0;
  dsac_xreq_s r;
  // 100 ns clock
  always #50 sys_clk = ~sys_clk;
  dsac_top u_dsac_top (.sys_clk, .srst, .x_req, .y_req, .y_ea, .stk, .sp_we,
    .sp_wdata, .stk_lim_we, .stk_lim_wdata, .addr_err_ack, .stk_err_ack,
    .mem_x_addr(xa), .mem_x_re(xre), .mem_x_we(xwe), .mem_x_be(xbe),
    .mem_x_wdata(xw), .mem_x_rdata(xr), .mem_y_addr(ya), .mem_y_re(yre),
    .mem_y_rdata(yr), .x_rvalid(xv), .x_rdata(xd), .wreg_be(wbe),
    .y_rvalid(yv), .y_rdata(yd), .ptr_upd(pu), .ptr_next(pn),
    .stack_pointer_reg(spr), .stack_limit_reg(lim), .addr_err_req(aer),
    .stk_err_req(ser));
  dsac_mem_model u_dsac_mem_model (.sys_clk, .x_addr(xa), .x_re(xre),
    .x_we(xwe), .x_be(xbe), .x_wdata(xw), .x_rdata(xr), .y_addr(ya),
    .y_re(yre), .y_rdata(yr));
  // inputs always change 1 ns after the rising edge
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic dsac_xreq_s mk(input logic we, bo,
                                    input logic [15:0] ea, wd);
    mk = '0;
    mk.valid = 1'b1;
    mk.we = we;
    mk.byte_op = bo;
    mk.postinc = 1'b1;
    mk.ea = ea;
    mk.wdata = wd;
  endfunction
  // idle edge, then one x request; returns while the strobes stand
  task xacc(input dsac_xreq_s q);
    cyc(1);
    x_req = q;
    cyc(1);
    x_req = '0;
  endtask
  // read and judge the returned word one cycle later
  task rd(input dsac_xreq_s q, input logic [15:0] exp);
    xacc(q);
    cyc(1);
    chk({15'h0, xv}, 16'h0001);
    chk(xd, exp);
  endtask
  task push(input dsac_push_e k, input logic [15:0] wd);
    cyc(1);
    stk = '{1'b1, 1'b0, k, wd, 8'h5c};
    cyc(1);
    stk = '0;
  endtask
  task t_word_byte;
    xacc(mk(1'b1, 1'b0, 16'h0100, 16'h1234));
    chk({15'h0, xwe}, 16'h0001);
    chk(pn, 16'h0102);
    xacc(mk(1'b1, 1'b1, 16'h0101, 16'h00ab));
    chk({14'h0, xbe}, {14'h0, BE_HIGH});
    chk(pn, 16'h0102);
    rd(mk(1'b0, 1'b0, 16'h0100, 16'h0), 16'hab34);
    chk({14'h0, wbe}, {14'h0, BE_WORD});
    rd(mk(1'b0, 1'b1, 16'h0101, 16'h0), 16'h00ab);
    chk({14'h0, wbe}, {14'h0, BE_LOW});
  endtask
  task t_misalign;
    xacc(mk(1'b1, 1'b0, 16'h0101, 16'hffff));
    chk({15'h0, xwe}, 16'h0000);
    cyc(2);
    chk({15'h0, aer}, 16'h0001);
    addr_err_ack = 1'b1;
    cyc(1);
    addr_err_ack = 1'b0;
    chk({15'h0, aer}, 16'h0000);
    rd(mk(1'b0, 1'b0, 16'h0100, 16'h0), 16'hab34);
  endtask
  task t_spaces;
    rd(mk(1'b0, 1'b0, 16'h2000, 16'h0), 16'h0000);
    xacc(mk(1'b1, 1'b0, 16'h0902, 16'h5678));
    r = mk(1'b0, 1'b0, 16'h0900, 16'h0);
    r.dual = 1'b1;
    cyc(1);
    {y_req, y_ea, x_req} = {1'b1, 16'h0902, r};
    cyc(1);
    x_req = '0;
    y_req = 1'b0;
    chk({15'h0, yre}, 16'h0001);
    cyc(1);
    chk(xd, 16'h0000);
    chk(yd, 16'h5678);
    y_req = 1'b1;
    y_ea = 16'h0100;
    cyc(1);
    y_req = 1'b0;
    cyc(1);
    chk({yv, yd[14:0]}, 16'h8000);
  endtask
  task t_modes;
    r = mk(1'b1, 1'b0, 16'he200, 16'h4321);
    r.mode = AM_NEAR;
    xacc(r);
    chk(xa, 16'h0200);
    r = mk(1'b1, 1'b0, 16'h0f00, 16'h2468);
    r.mode = AM_ABS16;
    xacc(r);
    chk(xa, 16'h0f00);
    r = mk(1'b1, 1'b0, 16'h0300, 16'h1357);
    r.bitrev = 1'b1;
    r.brev_ea = 16'h0204;
    xacc(r);
    chk(xa, 16'h0204);
    r.we = 1'b0;
    rd(r, 16'hc3c3);
  endtask
  task t_stack;
    logic [15:0] popped [4];
    popped = '{16'h2222, 16'h5ccd, 16'h00ab, 16'h1111};
    stk_lim_we = 1'b1;
    stk_lim_wdata = 16'h0805;
    cyc(1);
    stk_lim_we = 1'b0;
    chk(lim, 16'h0804);
    cyc(1);
    push(PK_DATA, 16'h1111);
    push(PK_PC_CALL, 16'h12ab);
    push(PK_PC_EXC, 16'h34cd);
    chk({15'h0, ser}, 16'h0000);
    push(PK_DATA, 16'h2222);
    chk({15'h0, ser}, 16'h0001);
    chk(spr, 16'h0808);
    cyc(1);
    stk_err_ack = 1'b1;
    for (int i = 0; i < 4; i++) begin
      stk.pop = 1'b1;
      cyc(1);
      stk = '0;
      stk_err_ack = 1'b0;
      cyc(1);
      chk(xd, popped[i]);
    end
    chk(spr, 16'h0800);
    sp_we = 1'b1;
    sp_wdata = 16'h07fe;
    cyc(1);
    sp_we = 1'b0;
    push(PK_DATA, 16'h3333);
    chk({15'h0, ser}, 16'h0001);
  endtask
  task conclude;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    conclude;
  end
  initial begin
    cyc(12);
    srst = 1'b0;
    t_word_byte;
    t_misalign;
    t_spaces;
    t_modes;
    t_stack;
    cyc(2);
    conclude;
  end
endmodule
`default_nettype wire
